// ---- core/pdw_pkg.sv ----
// power-down / wake-up control: shared constants, field layout, types
// assumes a 20 MHz reference clock and a 32-bit register bus
package pdw_pkg;

	// ----------------------------------------------------------------
	// bus geometry and clock gate count
	// ----------------------------------------------------------------
	localparam int          ADDR_W       = 6;
	localparam int          DATA_W       = 32;
	localparam int          GATE_N       = 4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0]  OFS_FER      = 6'h00; // function_enable_reg
	localparam logic [5:0]  OFS_PTR      = 6'h04; // power_and_test_reg
	localparam logic [5:0]  OFS_FCR      = 6'h08; // function_control_reg
	localparam logic [5:0]  OFS_PCR      = 6'h0c; // printer_control_reg
	localparam logic [5:0]  OFS_PMC      = 6'h10; // pin_tristate_control_reg
	localparam logic [5:0]  OFS_STATUS   = 6'h14; // power state, read only
	localparam logic [5:0]  OFS_FDC_CMD  = 6'h18; // floppy mode command
	localparam logic [5:0]  OFS_MSR      = 6'h1c; // floppy_main_status_reg
	localparam logic [5:0]  OFS_DSR      = 6'h20; // floppy data-rate select
	localparam logic [5:0]  OFS_DOR      = 6'h24; // floppy_digital_output_reg
	localparam logic [5:0]  OFS_FIFO     = 6'h28; // floppy data register

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          FER_PAR      = 0;
	localparam int          FER_UART1    = 1;
	localparam int          FER_UART2    = 2;
	localparam int          FER_FDC      = 3;
	localparam int          FER_IDE      = 6;
	localparam int          PTR_POWER_DOWN_PIN     = 0;
	localparam int          PTR_CLKSTOP  = 1;
	localparam int          PTR_PINOPT   = 2;
	localparam int          FCR_PINSEL   = 6;
	localparam int          PCR_PPBIT    = 2;
	localparam logic [7:0]  PMC_MASK     = 8'h47;
	localparam int          DSR_SWRST    = 7;
	localparam int          DSR_LOWPWR   = 6;
	localparam int          DOR_RESET    = 2;
	localparam int          MSR_RQM      = 7;
	localparam int          CMD_LOWPWR   = 0;
	localparam int          G_FDC        = 0;
	localparam int          G_UART1      = 1;
	localparam int          G_UART2      = 2;
	localparam int          G_ECP        = 3;

	// ----------------------------------------------------------------
	// reset values and strap codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  FER_RST      = 8'h4f;
	localparam logic [7:0]  PTR_RST      = 8'h00;
	localparam logic [7:0]  FCR_RST      = 8'h00;
	localparam logic [7:0]  PCR_RST      = 8'h00;
	localparam logic [7:0]  PMC_RST      = 8'h00;
	localparam logic [7:0]  DOR_RST      = 8'h00;
	localparam logic [4:0]  STRAP_MODE2  = 5'h01;
	localparam logic [4:0]  STRAP_MODE4  = 5'h02;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          STAB_TIME_US = 8000;
	localparam int          CLK_KHZ      = 20000;
	localparam int          STAB_CYCLES  = STAB_TIME_US * CLK_KHZ / 1000;

	// whole-chip power-down modes: {osc running, pins driven}
	typedef enum logic [1:0] {
		PDW_STOP_TRI = 2'b00,
		PDW_STOP_DRV = 2'b01,
		PDW_RUN_TRI  = 2'b10,
		PDW_RUN_DRV  = 2'b11
	} pdw_mode_t;

	// pin control bits all equal to the given value
	function automatic logic pdw_pmc_all(input logic [7:0] v, input logic val);
		pdw_pmc_all = ((v & PMC_MASK) == (val ? PMC_MASK : 8'h00));
	endfunction : pdw_pmc_all

endpackage : pdw_pkg

// ---- core/pdw_gate_if.sv ----
// clock gate requests and enables between control and gate cells
// assumes both ends share one reference clock
`timescale 1ns/1ps
`default_nettype none
interface pdw_gate_if #(parameter int N = 4);
	logic [N-1:0] req;
	logic [N-1:0] en;
	modport ctl  (output req, input en);
	modport gate (input req, output en);
endinterface : pdw_gate_if
`default_nettype wire

// ---- core/pdw_clk_gate.sv ----
// module clock gate enables, switched on the low clock phase
// assumes downstream ANDs each enable with the reference clock
`timescale 1ns/1ps
`default_nettype none
module pdw_clk_gate (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// request in, enable out
	pdw_gate_if.gate  g
);
	// ----------------------------------------------------------------
	// per-module enable flops
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < $bits(g.req); i++) begin : g_gate
			always_ff @(negedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					g.en[i] <= 1'b0;
				end else begin
					g.en[i] <= g.req[i];
				end
			end
		end
	endgenerate
endmodule : pdw_clk_gate
`default_nettype wire

// ---- core/pdw_top.sv ----
// power-down and wake-up control with an Avalon-MM register slave
// assumes synchronous pins and a single 20 MHz reference clock
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pdw_top import pdw_pkg::*; #(
	parameter int STAB_CYC = STAB_CYCLES
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	// pins
	input  wire logic              shared_chipsel_powerdown_pin_n,
	input  wire logic [4:0]        strap_config_inputs,
	// whole-chip state
	output logic                   chip_pd,
	output logic                   osc_stopped,
	output logic                   pins_tristate,
	output logic      [1:0]        pd_mode,
	output logic                   stab_busy,
	// module clock enables
	output logic                   fdc_clk_en,
	output logic                   uart1_clk_en,
	output logic                   uart2_clk_en,
	output logic                   ecp_clk_en
);
	localparam int STAB_W = $clog2(STAB_CYC + 1);

	logic [7:0]        fer_q, ptr_q, fcr_q, pcr_q, pmc_q, dor_q;
	logic              strap_done_q, wait_q, fdc_lp_q;
	logic [DATA_W-1:0] rdata_q;
	logic              chip_pd_q, osc_stop_q, tri_q, stab_busy_q;
	pdw_mode_t         mode_q;
	logic [STAB_W-1:0] stab_cnt_q;
	logic              acc, wr_en, rd_done, pin_pd, allow;
	logic              chip_pd_d, osc_stop_d, tri_d, request_for_master_flag, recover;
	logic [DATA_W-1:0] rdata_d;

	pdw_gate_if #(.N(GATE_N)) gate_if ();

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// access completes on the edge where waitrequest is low
	assign acc     = (avs_read | avs_write) & ~wait_q;
	assign wr_en   = avs_write & ~wait_q & avs_byteenable[0];
	assign rd_done = avs_read & ~wait_q;

	// one wait cycle, then one answer cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
		end
	end

	// read mux, unmapped reads as zero
	always_comb begin
		rdata_d = '0;
		unique case (avs_address)
			OFS_FER:    rdata_d[7:0] = fer_q;
			OFS_PTR:    rdata_d[7:0] = ptr_q;
			OFS_FCR:    rdata_d[7:0] = fcr_q;
			OFS_PCR:    rdata_d[7:0] = pcr_q;
			OFS_PMC:    rdata_d[7:0] = pmc_q;
			OFS_DOR:    rdata_d[7:0] = dor_q;
			OFS_STATUS: rdata_d[7:0] = {fdc_lp_q, stab_busy_q, mode_q, tri_q,
				osc_stop_q, chip_pd_q, request_for_master_flag};
			OFS_MSR:    rdata_d[MSR_RQM] = request_for_master_flag;
			default:    rdata_d = '0;
		endcase
	end

	// read data captured before the answer cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
		end else if (avs_read & wait_q) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// straps taken one cycle after reset release
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_q <= PTR_RST;
		end else if (!strap_done_q) begin
			if (strap_config_inputs == STRAP_MODE2) begin
				ptr_q[PTR_POWER_DOWN_PIN]    <= 1'b1;
				ptr_q[PTR_CLKSTOP] <= 1'b1;
			end else if (strap_config_inputs == STRAP_MODE4) begin
				ptr_q[PTR_POWER_DOWN_PIN] <= 1'b1;
			end
		end else if (wr_en && avs_address == OFS_PTR) begin
			ptr_q <= avs_writedata[7:0];
		end
	end

	// remaining software registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fer_q <= FER_RST;
			fcr_q <= FCR_RST;
			pcr_q <= PCR_RST;
			pmc_q <= PMC_RST;
			dor_q <= DOR_RST;
		end else if (wr_en) begin
			if (avs_address == OFS_FER) fer_q <= avs_writedata[7:0];
			if (avs_address == OFS_FCR) fcr_q <= avs_writedata[7:0];
			if (avs_address == OFS_PCR) pcr_q <= avs_writedata[7:0];
			if (avs_address == OFS_PMC) pmc_q <= avs_writedata[7:0];
			if (avs_address == OFS_DOR) dor_q <= avs_writedata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// floppy low power and recovery
	// ----------------------------------------------------------------
	// recovery triggers
	assign recover = (rd_done && (avs_address == OFS_MSR || avs_address == OFS_FIFO))
		|| (wr_en && avs_address == OFS_DSR && avs_writedata[DSR_SWRST])
		|| (wr_en && avs_address == OFS_DOR && avs_writedata[DOR_RESET]
			&& !dor_q[DOR_RESET]);

	// entry wins over recovery in the same cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fdc_lp_q <= 1'b0;
		end else if (wr_en && ((avs_address == OFS_FDC_CMD && avs_writedata[CMD_LOWPWR])
			|| (avs_address == OFS_DSR && avs_writedata[DSR_LOWPWR]))) begin
			fdc_lp_q <= 1'b1;
		end else if (recover && fer_q[FER_FDC] && !ptr_q[PTR_POWER_DOWN_PIN] && !pin_pd) begin
			// recovery ignores the crystal stop it is meant to end
			fdc_lp_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// whole-chip power-down decode
	// ----------------------------------------------------------------
	// shared pin qualification
	assign pin_pd = ~ptr_q[PTR_PINOPT] & fcr_q[FCR_PINSEL] & ~shared_chipsel_powerdown_pin_n;
	assign chip_pd_d = ptr_q[PTR_POWER_DOWN_PIN] | pin_pd
		| (({fer_q[FER_IDE], fer_q[3:0]} == 5'h00) & ~pcr_q[PCR_PPBIT]);
	assign osc_stop_d = ptr_q[PTR_CLKSTOP] & (chip_pd_d
		| (fer_q[FER_FDC] & fdc_lp_q & pdw_pmc_all(pmc_q, 1'b0)));
	assign tri_d = chip_pd_d & pdw_pmc_all(pmc_q, 1'b1);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chip_pd_q  <= 1'b0;
			osc_stop_q <= 1'b0;
			tri_q      <= 1'b0;
			mode_q     <= PDW_RUN_DRV;
		end else begin
			chip_pd_q  <= chip_pd_d;
			osc_stop_q <= osc_stop_d;
			tri_q      <= tri_d;
			mode_q     <= pdw_mode_t'({~osc_stop_d, ~tri_d});
		end
	end

	// ----------------------------------------------------------------
	// crystal stabilisation
	// ----------------------------------------------------------------
	// restart interval
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stab_busy_q <= 1'b0;
			stab_cnt_q  <= '0;
		end else if (osc_stop_d) begin
			stab_busy_q <= 1'b0;
			stab_cnt_q  <= '0;
		end else if (osc_stop_q) begin
			stab_busy_q <= 1'b1;
			stab_cnt_q  <= STAB_W'(STAB_CYC - 1);
		end else if (stab_busy_q) begin
			if (stab_cnt_q == '0) stab_busy_q <= 1'b0;
			else stab_cnt_q <= stab_cnt_q - 1'b1;
		end
	end

	assign request_for_master_flag = fdc_clk_en & ~fdc_lp_q & ~stab_busy_q;

	// ----------------------------------------------------------------
	// module clock gating
	// ----------------------------------------------------------------
	assign allow = ~ptr_q[PTR_POWER_DOWN_PIN] & ~pin_pd & ~osc_stop_q;

	assign gate_if.req[G_FDC]   = fer_q[FER_FDC] & allow & ~fdc_lp_q & ~stab_busy_q;
	assign gate_if.req[G_UART1] = fer_q[FER_UART1] & allow;
	assign gate_if.req[G_UART2] = fer_q[FER_UART2] & allow;
	assign gate_if.req[G_ECP]   = fer_q[FER_PAR] & allow;

	pdw_clk_gate u_gate (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.g       (gate_if.gate)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign chip_pd         = chip_pd_q;
	assign osc_stopped     = osc_stop_q;
	assign pins_tristate   = tri_q;
	assign pd_mode         = mode_q;
	assign stab_busy       = stab_busy_q;
	assign fdc_clk_en      = gate_if.en[G_FDC];
	assign uart1_clk_en    = gate_if.en[G_UART1];
	assign uart2_clk_en    = gate_if.en[G_UART2];
	assign ecp_clk_en      = gate_if.en[G_ECP];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_restart;
		osc_stop_q ##1 !osc_stop_q && !osc_stop_d;
	endsequence
	sequence s_msr_ask;
		avs_read && wait_q && avs_address == OFS_MSR;
	endsequence

	property p_stab_start;
		s_restart |-> stab_busy_q && stab_cnt_q == STAB_W'(STAB_CYC - 1);
	endproperty
	a_stab_start: assert property (p_stab_start) else $error("no stabilisation start");

	property p_rqm_clear;
		s_msr_ask and stab_busy_q |=> !avs_waitrequest && !avs_readdata[MSR_RQM];
	endproperty
	a_rqm_clear: assert property (p_rqm_clear) else $error("ready seen while stabilising");

	property p_uart_gate;
		uart1_clk_en |-> fer_q[FER_UART1] && !ptr_q[PTR_POWER_DOWN_PIN] && !pin_pd;
	endproperty
	a_uart_gate: assert property (p_uart_gate) else $error("serial clock ungated wrongly");

	property p_pin_opt;
		!ptr_q[PTR_PINOPT] && fcr_q[FCR_PINSEL] && !shared_chipsel_powerdown_pin_n |=> chip_pd;
	endproperty
	a_pin_opt: assert property (p_pin_opt) else $error("pin power-down ignored");

	property p_fdc_gate;
		fdc_clk_en |-> fer_q[FER_FDC] && !ptr_q[PTR_POWER_DOWN_PIN] && !pin_pd && !stab_busy_q;
	endproperty
	a_fdc_gate: assert property (p_fdc_gate) else $error("floppy clock ungated wrongly");

	property p_recover;
		recover && !ptr_q[PTR_POWER_DOWN_PIN] && !pin_pd && fer_q[FER_FDC]
			&& !(wr_en && avs_address == OFS_FDC_CMD)
			&& !(wr_en && avs_address == OFS_DSR && avs_writedata[DSR_LOWPWR]) |=> !fdc_lp_q;
	endproperty
	a_recover: assert property (p_recover) else $error("floppy recovery missed");

	property p_pd_mode;
		chip_pd_q && ptr_q[PTR_CLKSTOP] && pdw_pmc_all(pmc_q, 1'b1) && $stable(ptr_q)
			&& $stable(pmc_q) |-> osc_stopped && pins_tristate && pd_mode == PDW_STOP_TRI;
	endproperty
	a_pd_mode: assert property (p_pd_mode) else $error("wrong power-down mode");

	property p_fdc_stop;
		ptr_q[PTR_CLKSTOP] && fer_q[FER_FDC] && fdc_lp_q && pdw_pmc_all(pmc_q, 1'b0)
			|=> osc_stopped && !pins_tristate;
	endproperty
	a_fdc_stop: assert property (p_fdc_stop) else $error("crystal kept running");

	property p_strap;
		!strap_done_q && strap_config_inputs == STRAP_MODE2 |=> ##1 chip_pd && osc_stopped;
	endproperty
	a_strap: assert property (p_strap) else $error("strap mode not applied");

	property p_mode_code;
		pd_mode == PDW_RUN_TRI |-> !osc_stopped && pins_tristate && chip_pd;
	endproperty
	a_mode_code: assert property (p_mode_code) else $error("mode code mismatch");

endmodule : pdw_top
`default_nettype wire

// ---- sim/pdw_host_model.sv ----
// host software model: register bus master and wake-up waits
// assumes an avalon-mm slave on ref_clk that answers with waitrequest
`timescale 1ns/1ps
`default_nettype none
module pdw_host_model import pdw_pkg::*; (
	// clock
	input  wire logic              ref_clk,
	// avalon-mm master
	output logic      [ADDR_W-1:0] avs_address,
	output logic                   avs_read,
	output logic                   avs_write,
	output logic      [DATA_W-1:0] avs_writedata,
	output logic      [3:0]        avs_byteenable,
	input  wire logic [DATA_W-1:0] avs_readdata,
	input  wire logic              avs_waitrequest,
	// bus hang flag
	output logic                   hang
);
	// idle bus at time zero
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hf;
		hang = 1'b0;
	end

	// one bus cycle, held until waitrequest samples low
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
			input logic [3:0] be, output logic [31:0] rd);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		for (n = 0; n < 64; n++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 64) hang <= 1'b1;
	endtask : xfer

	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be = 4'hf);
		logic [31:0] r;
		xfer(1'b1, a, {24'h0, d}, be, r);
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0, 4'hf, d);
	endtask : rd

	task automatic poll_rqm(output int n);
		logic [31:0] d;
		for (n = 1; n <= 64; n++) begin
			rd(OFS_MSR, d);
			if (d[MSR_RQM] === 1'b1) break;
		end
		if (n > 64) hang <= 1'b1;
	endtask : poll_rqm

	task automatic time_stab(input int cyc);
		repeat (cyc) @(posedge ref_clk);
	endtask : time_stab
endmodule : pdw_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
// power-down control bench: reset, floppy wake-up, random configs, straps
// assumes pdw_top and the host model; stabilisation shortened to STAB
`timescale 1ns/1ps
`default_nettype none
module testbench import pdw_pkg::*;;
	localparam int         STAB = 20;
	localparam logic [5:0] RA[7] = '{OFS_FER, OFS_PTR, OFS_FCR, OFS_PCR, OFS_PMC, OFS_DOR, 6'h3c};
	localparam logic [7:0] RE[7] = '{8'h4f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic              ref_clk = 1'b0;
	logic              arst_n;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [DATA_W-1:0] avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic              pin_n;
	logic [4:0]        strap;
	logic              chip_pd;
	logic              osc_stopped;
	logic              pins_tristate;
	logic [1:0]        pd_mode;
	logic              stab_busy;
	logic              fdc_en;
	logic              u1_en;
	logic              u2_en;
	logic              ecp_en;
	logic              hang;
	logic [9:0]        outs;
	int                mismatches;
	int                samples_checked;
	int                seed;
	int                busy_cnt;

	assign outs = {chip_pd, osc_stopped, pins_tristate, pd_mode, stab_busy, fdc_en, u1_en, u2_en,
		ecp_en};

	pdw_top #(.STAB_CYC(STAB)) dut_u (
		.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.shared_chipsel_powerdown_pin_n(pin_n), .strap_config_inputs(strap),
		.chip_pd(chip_pd), .osc_stopped(osc_stopped), .pins_tristate(pins_tristate),
		.pd_mode(pd_mode), .stab_busy(stab_busy), .fdc_clk_en(fdc_en), .uart1_clk_en(u1_en),
		.uart2_clk_en(u2_en), .ecp_clk_en(ecp_en));

	pdw_host_model host_u (
		.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hang(hang));

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// cycles with stabilisation busy
	always @(posedge ref_clk) if (stab_busy === 1'b1) busy_cnt <= busy_cnt + 1;

	// expected {chip_pd, osc, tri, mode, busy, fdc, uart1, uart2, ecp}
	function automatic logic [9:0] exp_out(input logic [7:0] function_enable_reg, ptr, function_control_reg, printer_control_reg, pin_tristate_control_reg,
			input logic pn, lp);
		logic pp, cp, os, tr, g;
		pp = !ptr[2] && function_control_reg[6] && !pn;
		cp = ptr[0] || pp || ((function_enable_reg & 8'h4f) == 8'h00 && !printer_control_reg[2]);
		os = ptr[1] && (cp || (function_enable_reg[3] && lp && (pin_tristate_control_reg & PMC_MASK) == 8'h00));
		tr = cp && ((pin_tristate_control_reg & PMC_MASK) == PMC_MASK);
		g = !ptr[0] && !pp && !os;
		return {cp, os, tr, !os, !tr, 1'b0, function_enable_reg[3] && g && !lp, function_enable_reg[1] && g, function_enable_reg[2] && g, function_enable_reg[0] && g};
	endfunction : exp_out

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_reg

	task automatic chk_out(input logic [9:0] e);
		samples_checked++;
		if (outs !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, outs, e);
		end
	endtask : chk_out

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// reset with a strap code, held 2 cycles
	task automatic do_reset(input logic [4:0] s);
		@(posedge ref_clk);
		arst_n <= 1'b0;
		strap <= s;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : do_reset

	// hung bus ends the run
	always @(posedge hang) begin
		mismatches++;
		end_sim;
	end

	initial begin
		logic [31:0] d;
		int          n;
		logic [7:0]  fr, pt, fc, pc, pm;
		arst_n = 1'b0;
		pin_n = 1'b1;
		strap = 5'h00;
		seed = 32'hb81f;
		busy_cnt = 0;
		mismatches = 0;
		samples_checked = 0;
		do_reset(5'h00);
		// reset values, unmapped word, refused writes
		for (int i = 0; i < 7; i++) begin
			host_u.rd(RA[i], d);
			chk_reg(d, {24'h0, RE[i]});
		end
		chk_out(exp_out(8'h4f, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0));
		host_u.wr(OFS_FER, 8'h00, 4'h0);
		host_u.wr(6'h3c, 8'hff);
		host_u.rd(OFS_FER, d);
		chk_reg(d, 32'h4f);
		// floppy low power stops the crystal, each action recovers
		host_u.wr(OFS_FER, 8'h08);
		host_u.wr(OFS_PTR, 8'h02);
		for (int m = 0; m < 4; m++) begin
			if (m[0]) host_u.wr(OFS_DSR, 8'h40);
			else host_u.wr(OFS_FDC_CMD, 8'h01);
			host_u.time_stab(4);
			chk_out(exp_out(8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1));
			busy_cnt <= 0;
			case (m)
				0: host_u.wr(OFS_DSR, 8'h80);
				1: begin
					host_u.wr(OFS_DOR, 8'h00);
					host_u.wr(OFS_DOR, 8'h04);
				end
				2: host_u.rd(OFS_MSR, d);
				default: host_u.rd(OFS_FIFO, d);
			endcase
			host_u.rd(OFS_MSR, d);
			chk_reg(d & 32'h80, 32'h0);
			for (n = 0; n < 200 && !(stab_busy === 1'b0 && busy_cnt > 0); n++) @(posedge ref_clk);
			if (n == 200) begin
				mismatches++;
				end_sim;
			end
			chk_reg(busy_cnt, STAB);
			host_u.poll_rqm(n);
			chk_reg(n, 1);
			chk_out(exp_out(8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0));
		end
		// random power-down terms, first two with all functions off
		for (int i = 0; i < 40; i++) begin
			fr = (i < 2) ? 8'h30 : 8'($random(seed));
			pt = 8'($random(seed)) & 8'h07;
			fc = 8'($random(seed)) & 8'h40;
			pc = (i < 2) ? 8'(i * 4) : 8'($random(seed)) & 8'h04;
			pm = (i % 3 == 0) ? 8'h47 : (i % 3 == 1) ? 8'h00 : 8'($random(seed)) & 8'h47;
			host_u.wr(OFS_FER, fr);
			host_u.wr(OFS_PTR, pt);
			host_u.wr(OFS_FCR, fc);
			host_u.wr(OFS_PCR, pc);
			host_u.wr(OFS_PMC, pm);
			pin_n <= fr[7];
			host_u.time_stab(STAB + 8);
			chk_out(exp_out(fr, pt, fc, pc, pm, fr[7], 1'b0));
		end
		// strap-selected modes at reset
		pin_n <= 1'b1;
		for (int s = 1; s < 3; s++) begin
			do_reset(s == 1 ? STRAP_MODE2 : STRAP_MODE4);
			pt = (s == 1) ? 8'h03 : 8'h01;
			host_u.rd(OFS_PTR, d);
			chk_reg(d, {24'h0, pt});
			chk_out(exp_out(8'h4f, pt, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0));
		end
		end_sim;
	end
endmodule : testbench
`default_nettype wire
